/* hw/asr_map.svh */
// timing figures and widths for the host-side static memory controller
// assumes a 25 MHz system clock and the 3-V operating timing
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
`define ASR_CLK_PERIOD_NS      40
`define ASR_ADDR_W             13
`define ASR_DATA_W             8
// fast grade figures in ns
`define ASR_READ_CYCLE_FAST_NS 200
`define ASR_WRITE_PULSE_FAST_NS 140
`define ASR_SEL_WRITE_FAST_NS  150
`define ASR_DEV_RELEASE_FAST_NS 60
// slow grade figures in ns
`define ASR_READ_CYCLE_SLOW_NS 500
`define ASR_WRITE_PULSE_SLOW_NS 200
`define ASR_SEL_WRITE_SLOW_NS  250
`define ASR_DEV_RELEASE_SLOW_NS 120
// least times round up, at least one cycle
`define ASR_CYC_UP(ns)         ((((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS) < 1 ? 1 : \
                               (((ns) + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS))
`endif

/* hw/asr_pkg.sv */
// types for the host-side static memory controller
// assumes asr_map.svh for figures
`include "asr_map.svh"
package asr_pkg;
    typedef struct packed {
        logic                      write;
        logic [`ASR_ADDR_W-1:0]    addr;
        logic [`ASR_DATA_W-1:0]    wdata;
    } asr_req_s;
    typedef struct packed {
        logic                      sel_low_n;
        logic                      sel_high;
        logic                      gate_n;
        logic                      wstrobe_n;
    } asr_ctl_s;
    typedef enum logic [2:0] {
        ASR_IDLE, ASR_READ, ASR_WSETUP, ASR_WPULSE, ASR_RETAIN, ASR_WAKE
    } asr_state_e;
endpackage : asr_pkg

/* hw/asr_ctrl.sv */
// host controller driving an asynchronous 8-bit static memory
// assumes one 25 MHz clock; data_in comes from the pins and is synchronised
`include "asr_map.svh"
// Summary of operation
// - write strobe stays high through every read cycle
// - read cycle lasts at least the grade's read cycle time before data taken
// - write pulse lasts at least 140/200 ns with selects held asserted
// - chip stays selected during a write at least 150/250 ns
// - address may change right after a write ends
// - controller never drives data while the memory may drive it
// - output gate held steady high through every write cycle
// - chip deselected once the synchronised supply_ok is low and any read or write under way has ended
// - chip stays deselected one read cycle after supply returns
module asr_ctrl #(
    parameter bit SLOW_GRADE = 1'b0
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire asr_pkg::asr_req_s      req,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    output logic [`ASR_DATA_W-1:0]      rdata,
    output logic                        rdata_valid,
    input  wire logic                   retain_req,
    input  wire logic                   supply_ok,
    output logic                        retaining,
    output logic [`ASR_ADDR_W-1:0]      addr_lines,
    output asr_pkg::asr_ctl_s           ctl,
    output logic [`ASR_DATA_W-1:0]      data_out,
    output logic                        data_oe,
    input  wire logic [`ASR_DATA_W-1:0] data_in
);
    import asr_pkg::*;

    localparam int RD_CYC  = SLOW_GRADE ? `ASR_CYC_UP(`ASR_READ_CYCLE_SLOW_NS) : `ASR_CYC_UP(`ASR_READ_CYCLE_FAST_NS);
    localparam int WP_CYC  = SLOW_GRADE ? `ASR_CYC_UP(`ASR_WRITE_PULSE_SLOW_NS)
                                        : `ASR_CYC_UP(`ASR_WRITE_PULSE_FAST_NS);
    localparam int SW_CYC  = SLOW_GRADE ? `ASR_CYC_UP(`ASR_SEL_WRITE_SLOW_NS) : `ASR_CYC_UP(`ASR_SEL_WRITE_FAST_NS);
    localparam int REL_CYC = SLOW_GRADE ? `ASR_CYC_UP(`ASR_DEV_RELEASE_SLOW_NS)
                                        : `ASR_CYC_UP(`ASR_DEV_RELEASE_FAST_NS);
    // the write pulse must cover both the strobe and select minimums
    localparam int PULSE_CYC = (WP_CYC > SW_CYC) ? WP_CYC : SW_CYC;
    // the sync path costs two cycles; data is sampled on the last read cycle
    localparam int CNT_W = 5;

    // refuse grades whose counts overflow the cycle counter
    if (RD_CYC < 3 || RD_CYC + 1 >= (1 << CNT_W) || PULSE_CYC >= (1 << CNT_W)) begin : g_bad_timing
        $error("asr_ctrl: timing counts out of range");
    end

    asr_state_e                 state_ff, nxt_state;
    logic [CNT_W-1:0]           cnt_ff, nxt_cnt;
    logic [`ASR_DATA_W-1:0]     din_meta_ff, din_sync_ff;
    logic [1:0]                 sup_ff;
    logic [1:0]                 ret_ff;
    logic                       rdone;

    // pin inputs pass two flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            din_meta_ff <= '0;
            din_sync_ff <= '0;
            sup_ff      <= 2'h0;
            ret_ff      <= 2'h0;
        end else begin
            din_meta_ff <= data_in;
            din_sync_ff <= din_meta_ff;
            sup_ff      <= {sup_ff[0], supply_ok};
            ret_ff      <= {ret_ff[0], retain_req};
        end
    end

    wire sup_good  = sup_ff[1];
    wire want_rest = ret_ff[1];
    wire cnt_done  = (cnt_ff == '0);
    wire take_req  = (state_ff == ASR_IDLE) && req_valid && !want_rest && sup_good;
    assign rdone   = (state_ff == ASR_READ) && cnt_done;

    // sequencing of read, write, retention entry and exit
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 5'h01;
        case (state_ff)
            ASR_IDLE: begin
                if (want_rest || !sup_good) begin
                    nxt_state = ASR_RETAIN;
                end else if (take_req && req.write) begin
                    nxt_state = ASR_WSETUP;
                    nxt_cnt   = CNT_W'(REL_CYC - 1);
                end else if (take_req) begin
                    nxt_state = ASR_READ;
                    nxt_cnt   = CNT_W'(RD_CYC + 1);
                end
            end
            ASR_READ: if (cnt_done) nxt_state = ASR_IDLE;
            ASR_WSETUP: if (cnt_done) begin
                nxt_state = ASR_WPULSE;
                nxt_cnt   = CNT_W'(PULSE_CYC - 1);
            end
            ASR_WPULSE: if (cnt_done) nxt_state = ASR_IDLE;
            ASR_RETAIN: if (!want_rest && sup_good) begin
                nxt_state = ASR_WAKE;
                nxt_cnt   = CNT_W'(RD_CYC - 1);
            end
            ASR_WAKE: if (!sup_good) nxt_state = ASR_RETAIN;
                else if (cnt_done) nxt_state = ASR_IDLE;
            default: nxt_state = ASR_IDLE;
        endcase
    end

    // pin levels decoded from the next state so the pins come from flip-flops
    wire n_sel   = (nxt_state == ASR_READ) || (nxt_state == ASR_WSETUP) || (nxt_state == ASR_WPULSE);
    wire n_wr    = (nxt_state == ASR_WPULSE);
    wire n_oe    = (nxt_state == ASR_WPULSE);    // drive only under the strobe
    wire n_gate  = (nxt_state == ASR_READ);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ASR_IDLE;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // control pins, address and write data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl        <= '{sel_low_n: 1'b1, sel_high: 1'b0, gate_n: 1'b1, wstrobe_n: 1'b1};
            addr_lines <= '0;
            data_out   <= '0;
            data_oe    <= 1'b0;
        end else begin
            ctl.sel_low_n <= !n_sel;
            ctl.sel_high  <= n_sel;
            ctl.gate_n    <= !n_gate;
            ctl.wstrobe_n <= !n_wr;
            data_oe       <= n_oe;
            if (take_req) begin
                addr_lines <= req.addr;
                data_out   <= req.wdata;
            end
        end
    end

    // host side handshake and read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_ready   <= 1'b0;
            rdata       <= '0;
            rdata_valid <= 1'b0;
            retaining   <= 1'b0;
        end else begin
            req_ready   <= (nxt_state == ASR_IDLE) && !want_rest && sup_good && !take_req;
            rdata_valid <= rdone;
            if (rdone) rdata <= din_sync_ff;
            retaining   <= (nxt_state == ASR_RETAIN);
        end
    end

    // counts how long the strobe has been low, for the pulse check
    logic [CNT_W-1:0] wp_len_ff;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) wp_len_ff <= '0;
        else if (ctl.wstrobe_n) wp_len_ff <= '0;
        else if (wp_len_ff != '1) wp_len_ff <= wp_len_ff + 5'h01;
    end

    // write strobe never falls while the gate is open for a read
    a_strobe_read_high: assert property (@(posedge clk) disable iff (!nrst)
        !ctl.gate_n |-> ctl.wstrobe_n) else $error("strobe low in read");

    // strobe low time covers the pulse and select minimums
    a_pulse_len_min: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ctl.wstrobe_n) |-> wp_len_ff >= CNT_W'(PULSE_CYC)) else $error("write pulse short");

    // both selects stay asserted under the strobe
    a_sel_during_wr: assert property (@(posedge clk) disable iff (!nrst)
        !ctl.wstrobe_n |-> !ctl.sel_low_n && ctl.sel_high) else $error("deselect in write");

    // data pins driven only with the output gate shut
    a_no_contention: assert property (@(posedge clk) disable iff (!nrst)
        data_oe |-> ctl.gate_n) else $error("drive while gate low");

    // no drive for two cycles after a read, the fast grade release time
    a_oe_after_read: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ctl.gate_n) |-> !data_oe [*2]) else $error("drive too soon after read");

    // gate held high and still while the strobe is low
    a_gate_steady_wr: assert property (@(posedge clk) disable iff (!nrst)
        !ctl.wstrobe_n |-> ctl.gate_n && $stable(ctl.gate_n)) else $error("gate moved in write");

    // low-active select inactive in retention
    a_retain_desel: assert property (@(posedge clk) disable iff (!nrst)
        retaining |-> ctl.sel_low_n) else $error("selected in retention");

    // high-active select inactive in retention
    a_retain_sel_high: assert property (@(posedge clk) disable iff (!nrst)
        retaining |-> !ctl.sel_high) else $error("high select active in retention");

    // at least one fast read cycle of deselect after waking
    a_wake_hold: assert property (@(posedge clk) disable iff (!nrst)
        $fell(retaining) |-> ctl.sel_low_n [*5]) else $error("selected early after wake");

    // address steady while selected
    a_addr_stable: assert property (@(posedge clk) disable iff (!nrst)
        (!ctl.sel_low_n && !$past(ctl.sel_low_n)) |-> $stable(addr_lines)) else $error("addr moved");

    // gate open for at least a fast read cycle
    a_read_len: assert property (@(posedge clk) disable iff (!nrst)
        $fell(ctl.gate_n) |-> !ctl.gate_n [*5]) else $error("read too short");

    // read byte taken only after the gate has been open five cycles
    a_read_data_late: assert property (@(posedge clk) disable iff (!nrst)
        rdata_valid |-> $past(ctl.gate_n, 5) == 1'b0) else $error("read data taken early");
endmodule : asr_ctrl

/* tb/asr_mem_model.sv */
// behavioural model of the 8-bit static memory on the far side of the pins
// assumes the controller's pin outputs and the resolved data bus from the bench
`include "asr_map.svh"
module asr_mem_model (
    input  wire logic [`ASR_ADDR_W-1:0] addr_lines,
    input  wire asr_pkg::asr_ctl_s      ctl,
    input  wire logic [`ASR_DATA_W-1:0] bus,
    output logic [`ASR_DATA_W-1:0]      dq,
    output logic                        drive
);
    timeunit 1ns;
    timeprecision 1ns;
    import asr_pkg::*;
    logic [`ASR_DATA_W-1:0] mem [0:(1<<`ASR_ADDR_W)-1];
    logic [`ASR_DATA_W-1:0] wb;
    logic [`ASR_DATA_W-1:0] last = '0;
    logic [`ASR_ADDR_W-1:0] wa;
    wire sel = ~ctl.sel_low_n & ctl.sel_high;
    wire en  = sel & ~ctl.gate_n & ctl.wstrobe_n;
    wire wr  = sel & ~ctl.wstrobe_n;
    wire [`ASR_DATA_W-1:0] bus_d;
    assign #1 bus_d = bus;
    // late turn-on, release well inside the allowed time
    initial drive = 1'b0;
    always @(en) drive <= #(en ? 20 : 50) en;
    // released pins show the inverse of the last byte, never a held value
    always @(*) if (drive) last = mem[addr_lines];
    assign dq = drive ? mem[addr_lines] : ~last;
    // latch write data while the pulse lasts, store it when the pulse ends
    always @(*) if (wr) begin
        wa = addr_lines;
        wb = bus_d;
    end
    always @(negedge wr) mem[wa] <= wb;
endmodule : asr_mem_model

/* tb/test_async_sram_3v_bus_timing.sv */
// self-checking bench for the static memory controller, fast grade
// assumes asr_ctrl and asr_mem_model; one 25 MHz clock
`include "asr_map.svh"
module test_async_sram_3v_bus_timing;
    timeunit 1ns;
    timeprecision 1ns;
    import asr_pkg::*;
    logic clk, nrst, req_valid, req_ready, rdata_valid, retain_req, supply_ok, retaining, data_oe, drive;
    asr_req_s req;
    asr_ctl_s ctl;
    logic [`ASR_DATA_W-1:0] rdata, data_out, dq;
    logic [`ASR_ADDR_W-1:0] addr_lines, pa;
    wire  [`ASR_DATA_W-1:0] bus = data_oe ? data_out : dq;
    wire sel = ~ctl.sel_low_n & ctl.sel_high;
    int error_cnt = 0, n_checks = 0, cyc = 0, wl = 0, ps = 0;
    asr_ctrl dut (.clk, .nrst, .req, .req_valid, .req_ready, .rdata, .rdata_valid, .retain_req, .supply_ok,
        .retaining, .addr_lines, .ctl, .data_out, .data_oe, .data_in(bus));
    asr_mem_model mem (.addr_lines, .ctl, .bus, .dq, .drive);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(string what, logic [12:0] exp, logic [12:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // one request held until the controller takes it; a read waits for its byte
    task automatic xfer(logic wr, logic [12:0] a, logic [7:0] d, output logic [7:0] got, output int n);
        n = 0;
        @(posedge clk);
        req <= '{wr, a, d};
        req_valid <= 1'b1;
        #1;
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        while (!wr && rdata_valid !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
        got = rdata;
    endtask : xfer
    // back-to-back writes at both address ends, then read each back
    task automatic t_rw();
        logic [7:0] g;
        int n;
        logic [12:0] a[3] = '{13'h0000, 13'h1FFF, 13'h0A55};
        logic [7:0] d[3] = '{8'hA5, 8'h3C, 8'hFF};
        for (int i = 0; i < 3; i++) xfer(1'b1, a[i], d[i], g, n);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b0, a[i], 8'h00, g, n);
            chk("read byte", d[i], g);
            chk("read cycle length", 1, n >= 5);
        end
        $display("test read write done");
    endtask : t_rw
    // enter retention, drop and restore supply, wake and read back
    task automatic t_retain();
        logic [7:0] g;
        int n;
        @(posedge clk);
        retain_req <= 1'b1;
        n = 0;
        while (retaining !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
        chk("retaining", 1, retaining);
        chk("deselected", 0, sel);
        @(posedge clk);
        supply_ok <= 1'b0;
        retain_req <= 1'b0;
        repeat (10) @(posedge clk);
        supply_ok <= 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
        chk("wake hold", 1, n >= 5);
        xfer(1'b0, 13'h1FFF, 8'h00, g, n);
        chk("byte kept", 8'h3C, g);
        $display("test retention done");
    endtask : t_retain
    // pin rules watched on every rising edge out of reset, plus the run ceiling
    always @(posedge clk) begin
        cyc++;
        if (nrst) begin
            if (data_oe && drive) chk("contention", 0, 1);
            if (data_oe) chk("gate in write", 1, ctl.gate_n);
            if (!ctl.gate_n) chk("strobe in read", 1, ctl.wstrobe_n);
            if (retaining === 1'b1) chk("sel in retention", 0, sel);
            if (ps && sel) chk("addr stable", pa, addr_lines);
            if (!ctl.wstrobe_n) wl++;
            else if (wl) begin chk("write pulse", 1, wl >= 4); wl = 0; end
        end
        ps = sel;
        pa = addr_lines;
        if (cyc > 20000) begin error_cnt++; results(); end
    end
    initial begin
        nrst = 1'b0;
        req_valid = 1'b0;
        req = '0;
        retain_req = 1'b0;
        supply_ok = 1'b1;
        repeat (12) @(posedge clk);
        chk("reset pins", 13'h0016, {ctl, data_oe});
        nrst <= 1'b1;
        t_rw();
        t_retain();
        results();
    end
endmodule : test_async_sram_3v_bus_timing
